// *** dv/ebm_bus_master_props.sv ***
// assertion checker for the external bus master ports
`timescale 1ns/100ps
`include "ebm_defines.vh"
module ebm_bus_master_props (
  input wire clk,
  input wire rst_n,
  input wire req_valid,
  input wire req_ready,
  input wire req_write,
  input wire [1:0] req_size,
  input wire req_code,
  input wire req_super,
  input wire [1:0] port_width,
  input wire burst_en,
  input wire dram_hit,
  input wire bmt_enable,
  input wire rsp_valid,
  input wire rsp_err,
  input wire xfer_dir,
  input wire access_mode_flag,
  input wire [1:0] xfer_width_code,
  input wire cycle_start_n,
  input wire cycle_ack_n,
  input wire data_oe_n
);
  // ----------
  // strobe count since accept
  // ----------
  reg [4:0] starts_q;
  reg burst_q;
  wire take = req_valid && req_ready;
  // a burst must reuse the single opening strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      starts_q <= 5'h00;
      burst_q <= 1'h0;
    end else if (take) begin
      starts_q <= 5'h00;
      burst_q <= burst_en | dram_hit;
    end else if (!cycle_start_n) begin
      starts_q <= starts_q + 5'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_after_take: assert property (take |=> !cycle_start_n)
    else $error("no start strobe after accept");
  a_start_one_clk: assert property (!cycle_start_n |=> cycle_start_n)
    else $error("start strobe longer than one clock");
  a_mode_code_dir: assert property (take |=> access_mode_flag == $past(req_code) && xfer_dir == !$past(req_write))
    else $error("first clock mode or direction wrong");
  a_mode_super: assert property (take |=> ##1 cycle_start_n && access_mode_flag == $past(req_super, 2))
    else $error("second clock mode wrong");
  a_width_burst: assert property (take && (burst_en || dram_hit) |=> xfer_width_code == $past(req_size))
    else $error("burst width code not operand size");
  a_width_port: assert property (take && !burst_en && !dram_hit && !req_write && req_size == `EBM_SZ_LINE
    |=> xfer_width_code == $past(port_width))
    else $error("inhibited width code not port size");
  a_ack_ends: assert property (rsp_valid |-> !$past(cycle_ack_n) || $past(bmt_enable))
    else $error("cycle ended without ack");
  a_data_second: assert property (take && req_write |=> ##1 !data_oe_n)
    else $error("write data not driven in second clock");
  a_data_release: assert property (rsp_valid |-> data_oe_n)
    else $error("data bus not released after write");
  a_one_strobe: assert property (rsp_valid && burst_q |-> starts_q == 5'h01)
    else $error("burst used more than one start strobe");
  cover property (rsp_valid && rsp_err);
  cover property (rsp_valid && burst_q && xfer_width_code == `EBM_SZ_LINE);
  cover property (take && req_write);
endmodule
bind ebm_bus_master ebm_bus_master_props u_props (.clk, .rst_n, .req_valid, .req_ready, .req_write, .req_size,
  .req_code, .req_super, .port_width, .burst_en, .dram_hit, .bmt_enable, .rsp_valid, .rsp_err, .xfer_dir,
  .access_mode_flag, .xfer_width_code, .cycle_start_n, .cycle_ack_n, .data_oe_n);

// *** dv/ebm_slave_model.sv ***
// behavioural slave on the far side of the external bus
`timescale 1ns/100ps
`include "ebm_defines.vh"
module ebm_slave_model (
  input wire clk,
  input wire rst_n,
  input wire [27:0] bus_addr,
  input wire [1:0] xfer_width_code,
  input wire xfer_dir,
  input wire cycle_start_n,
  input wire [31:0] data_out,
  input wire [1:0] pw,
  input wire [3:0] waits,
  input wire mute,
  output wire cycle_ack_n,
  output reg [31:0] data_in,
  output reg [31:0] wr_seen
);
  reg ph_q;
  reg [3:0] left_q;
  reg [3:0] wc_q;
  reg [4:0] opb;
  reg [4:0] ptb;
  reg [3:0] beats;
  integer i;
  // memory content is a simple function of the byte address
  function automatic [7:0] mb(input [27:0] a);
    mb = a[7:0] ^ 8'h5A;
  endfunction
  assign cycle_ack_n = !(ph_q && wc_q == 4'h0 && !mute);
  // lanes by port width, undriven lanes show the inverse
  always @* begin
    opb = xfer_width_code == `EBM_SZ_LINE ? 5'h10 : xfer_width_code == `EBM_SZ_LONG ? 5'h04 : {3'h0, xfer_width_code};
    ptb = pw == `EBM_PORT_32 ? 5'h04 : {3'h0, pw};
    beats = (opb > ptb && xfer_dir) ? 4'(opb / ptb - 5'h01) : 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      data_in[31-8*i -: 8] = ~mb(bus_addr);
      if (pw == `EBM_PORT_32) data_in[31-8*i -: 8] = mb({bus_addr[27:2], i[1:0]});
      else if (i < ptb) data_in[31-8*i -: 8] = mb(pw == `EBM_PORT_16 ? {bus_addr[27:1], i[0]} : bus_addr);
    end
    if (!ph_q) data_in = ~data_in;
  end
  // data phase: wait count, then ack each beat
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 1'h0;
      left_q <= 4'h0;
      wc_q <= 4'h0;
      wr_seen <= 32'h00000000;
    end else if (!cycle_start_n) begin
      ph_q <= 1'h1;
      left_q <= beats;
      wc_q <= waits;
    end else if (ph_q && wc_q != 4'h0) begin
      wc_q <= wc_q - 4'h1;
    end else if (ph_q && !mute) begin
      ph_q <= left_q != 4'h0;
      left_q <= left_q - 4'h1;
      wc_q <= waits;
      if (!xfer_dir) wr_seen <= data_out;
    end
  end
endmodule

// *** dv/external_bus_master_cycles_tb.sv ***
// self-checking bench for the external bus master
`timescale 1ns/100ps
`include "ebm_defines.vh"
module external_bus_master_cycles_tb;
  reg clk = 1'h0;
  reg rst_n = 1'h0;
  reg req_valid = 1'h0;
  reg req_write = 1'h0;
  reg [27:0] req_addr = 28'h0000000;
  reg [1:0] req_size = 2'h0;
  reg [1:0] req_kind = 2'h0;
  reg req_code = 1'h0;
  reg req_super = 1'h0;
  reg [31:0] req_wdata = 32'h00000000;
  reg [1:0] port_width = 2'h0;
  reg burst_en = 1'h0;
  reg dram_hit = 1'h0;
  reg bmt_enable = 1'h0;
  reg [7:0] bmt_limit = 8'h00;
  reg [3:0] waits = 4'h0;
  reg mute = 1'h0;
  wire req_ready, rsp_valid, rsp_err, busy, access_mode_flag, xfer_dir, cycle_start_n, cycle_ack_n, data_oe_n;
  wire [127:0] rsp_rdata;
  wire [27:0] bus_addr;
  wire [1:0] access_kind_code, xfer_width_code;
  wire [31:0] data_in, data_out, wr_seen;
  integer mismatches = 0;
  integer tests_run = 0;
  integer lat;
  ebm_bus_master DUT (.clk, .rst_n, .req_valid, .req_ready, .req_write, .req_addr, .req_size, .req_kind,
    .req_code, .req_super, .req_wdata, .port_width, .burst_en, .dram_hit, .bmt_enable, .bmt_limit, .rsp_valid,
    .rsp_err, .rsp_rdata, .busy, .bus_addr, .access_kind_code, .access_mode_flag, .xfer_dir, .xfer_width_code,
    .cycle_start_n, .cycle_ack_n, .data_in, .data_out, .data_oe_n);
  ebm_slave_model u_slave (.clk, .rst_n, .bus_addr, .xfer_width_code, .xfer_dir, .cycle_start_n, .data_out,
    .pw(port_width), .waits, .mute, .cycle_ack_n, .data_in, .wr_seen);
  always #10 clk = ~clk;
  // ----------
  // shared tasks
  // ----------
  task chk(input string what, input [127:0] exp, input [127:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // one request, then a bounded wait for the response pulse
  task run(input wr, input [27:0] a, input [1:0] sz, input [31:0] wd);
    begin
      req_valid <= 1'h1;
      req_write <= wr;
      req_addr <= a;
      req_size <= sz;
      req_wdata <= wd;
      req_kind <= req_kind + 2'h1;
      @(posedge clk);
      chk("ready", 128'h1, {127'h0, req_ready});
      req_valid <= 1'h0;
      // first clock of the cycle: kind code out and the block busy
      @(posedge clk);
      lat = 1;
      chk("kind", {126'h0, req_kind}, {126'h0, access_kind_code});
      chk("busy", 128'h1, {127'h0, busy});
      while (rsp_valid !== 1'h1 && lat < 400) begin
        @(posedge clk);
        lat = lat + 1;
      end
      if (lat >= 400) begin
        mismatches = mismatches + 1;
        tally_and_finish;
      end
    end
  endtask
  // expected read image: block bytes from block base, rest zero
  function [127:0] img(input [27:0] a, input [1:0] sz);
    integer j;
    reg [4:0] nb;
    reg [27:0] b;
    begin
      nb = sz == `EBM_SZ_LINE ? 5'h10 : sz == `EBM_SZ_LONG ? 5'h04 : {3'h0, sz};
      b = a & ~({23'h0, nb} - 28'h1);
      img = 128'h0;
      for (j = 0; j < nb; j = j + 1) img[127-8*j -: 8] = (b[7:0] + j[7:0]) ^ 8'h5A;
    end
  endfunction
  // expected write lanes, don't-care lanes zero
  function [31:0] lanes(input [1:0] sz, input [1:0] off, input [31:0] w);
    reg [7:0] o0, o1, o2, o3;
    begin
      {o0, o1, o2, o3} = w;
      case (sz)
        `EBM_SZ_BYTE: lanes = {o3, off[0] ? o3 : 8'h00, off == 2'h2 ? o3 : 8'h00, off == 2'h3 ? o3 : 8'h00};
        `EBM_SZ_WORD: lanes = off[0] ? {o3, 24'h0} : {o2, o3, off[1] ? {o2, o3} : 16'h0};
        default: lanes = off == 2'h0 ? w : off == 2'h1 ? {o1, 24'h0} : off == 2'h2 ? {o2, o3, 16'h0} : {o3, 24'h0};
      endcase
    end
  endfunction
  task rd(input [27:0] a, input [1:0] sz, input [1:0] pw, input be, input dr, input [3:0] w, input integer nb);
    begin
      port_width <= pw;
      burst_en <= be;
      dram_hit <= dr;
      waits <= w;
      run(1'h0, a, sz, 32'h0);
      chk("read image", img(a, sz), rsp_rdata);
      chk("read error", 128'h0, {127'h0, rsp_err});
      if (nb > 0) chk("read latency", 2 + nb * (w + 1), lat);
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task t_single;
    begin
      req_code <= 1'h1;
      req_super <= 1'h1;
      rd(28'h0000100, `EBM_SZ_LONG, `EBM_PORT_32, 1'h0, 1'h0, 4'h0, 1);
      rd(28'h0000103, `EBM_SZ_BYTE, `EBM_PORT_32, 1'h0, 1'h0, 4'h3, 1);
    end
  endtask
  task t_bursts;
    begin
      req_super <= 1'h0;
      rd(28'h0000218, `EBM_SZ_LINE, `EBM_PORT_32, 1'h1, 1'h0, 4'h2, 4);
      rd(28'h0000332, `EBM_SZ_WORD, `EBM_PORT_8, 1'h0, 1'h1, 4'h0, 2);
      rd(28'h0000440, `EBM_SZ_LONG, `EBM_PORT_16, 1'h1, 1'h0, 4'h1, 2);
      rd(28'h0000504, `EBM_SZ_LINE, `EBM_PORT_8, 1'h1, 1'h0, 4'h0, 16);
    end
  endtask
  task t_inhibit;
    begin
      req_code <= 1'h0;
      rd(28'h0000620, `EBM_SZ_LINE, `EBM_PORT_16, 1'h0, 1'h0, 4'h1, 0);
      // eight word beats, each a start clock, one wait and the ack clock
      chk("inhibit latency", 1 + 8 * (1 + 2), lat);
    end
  endtask
  task t_writes;
    integer s;
    integer o;
    begin
      port_width <= `EBM_PORT_32;
      burst_en <= 1'h0;
      dram_hit <= 1'h0;
      waits <= 4'h1;
      for (s = 0; s < 4; s = s + 1)
        for (o = 0; o < 4; o = o + 1) begin
          run(1'h1, {24'h0000008, s[1:0], o[1:0]}, s[1:0], 32'hC1D2E3F4);
          chk("write lanes", lanes(s[1:0], o[1:0], 32'hC1D2E3F4), wr_seen);
          // a line write to a 32-bit port without burst runs as four one-beat cycles
          chk("write latency", s == 3 ? 1 + 4 * 3 : 4, lat);
        end
    end
  endtask
  // silent slave: bus monitor must end the cycle
  task t_timeout;
    begin
      mute <= 1'h1;
      bmt_enable <= 1'h1;
      bmt_limit <= 8'h05;
      run(1'h0, 28'h0000900, `EBM_SZ_LONG, 32'h0);
      chk("bus error", 128'h1, {127'h0, rsp_err});
      chk("error latency", 128'h7, lat);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    t_single;
    t_bursts;
    t_inhibit;
    t_writes;
    t_timeout;
    tally_and_finish;
  end
endmodule

// *** verilog/ebm_bus_master.v ***
// bus master for single and bursting cycles on the external memory bus
`timescale 1ns/100ps
`include "ebm_defines.vh"

module ebm_bus_master (
  clk,
  rst_n,
  req_valid,
  req_ready,
  req_write,
  req_addr,
  req_size,
  req_kind,
  req_code,
  req_super,
  req_wdata,
  port_width,
  burst_en,
  dram_hit,
  bmt_enable,
  bmt_limit,
  rsp_valid,
  rsp_err,
  rsp_rdata,
  busy,
  bus_addr,
  access_kind_code,
  access_mode_flag,
  xfer_dir,
  xfer_width_code,
  cycle_start_n,
  cycle_ack_n,
  data_in,
  data_out,
  data_oe_n
);
  input wire clk;
  input wire rst_n;
  input wire req_valid;
  output wire req_ready;
  input wire req_write;
  input wire [`EBM_ADDR_W-1:0] req_addr;
  input wire [1:0] req_size;
  input wire [1:0] req_kind;
  input wire req_code;
  input wire req_super;
  input wire [`EBM_DATA_W-1:0] req_wdata;
  input wire [1:0] port_width;
  input wire burst_en;
  input wire dram_hit;
  input wire bmt_enable;
  input wire [`EBM_BMT_W-1:0] bmt_limit;
  output reg rsp_valid;
  output reg rsp_err;
  output wire [`EBM_LINE_W-1:0] rsp_rdata;
  output wire busy;
  output wire [`EBM_ADDR_W-1:0] bus_addr;
  output reg [1:0] access_kind_code;
  output reg access_mode_flag;
  output reg xfer_dir;
  output reg [1:0] xfer_width_code;
  output reg cycle_start_n;
  input wire cycle_ack_n;
  input wire [`EBM_DATA_W-1:0] data_in;
  output reg [`EBM_DATA_W-1:0] data_out;
  output reg data_oe_n;

  // ------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;

  // ------------------------------------------------------------
  // size decoding shared by request and beat logic
  // ------------------------------------------------------------

  // bytes in an operand of the given size code
  function [4:0] op_bytes;
    input [1:0] sz;
    begin
      case (sz)
        `EBM_SZ_BYTE: op_bytes = 5'h01;
        `EBM_SZ_WORD: op_bytes = 5'h02;
        `EBM_SZ_LONG: op_bytes = 5'h04;
        default: op_bytes = 5'h10;
      endcase
    end
  endfunction

  // bytes carried by one beat of a port
  function [4:0] port_bytes;
    input [1:0] pw;
    begin
      case (pw)
        `EBM_PORT_8: port_bytes = 5'h01;
        `EBM_PORT_16: port_bytes = 5'h02;
        default: port_bytes = 5'h04;
      endcase
    end
  endfunction

  // log2 of the port byte count, used to divide into beats
  function [1:0] port_shift;
    input [1:0] pw;
    begin
      case (pw)
        `EBM_PORT_8: port_shift = 2'h0;
        `EBM_PORT_16: port_shift = 2'h1;
        default: port_shift = 2'h2;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // reset release through two flip-flops
  // ------------------------------------------------------------
  reg [1:0] rst_sync_q;
  wire rst_l_n = rst_sync_q[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ------------------------------------------------------------
  // request latch and burst decision
  // ------------------------------------------------------------
  reg [1:0] state_q;
  reg [`EBM_ADDR_W-1:0] addr_q;
  reg [1:0] size_q;
  reg [1:0] port_q;
  reg write_q;
  reg code_q;
  reg super_q;
  reg burst_q;
  reg [`EBM_DATA_W-1:0] wdata_q;
  reg [4:0] beats_q;
  reg [`EBM_BMT_W-1:0] bmt_cnt_q;

  wire accept = req_valid && (state_q == ST_IDLE);
  assign req_ready = (state_q == ST_IDLE);
  assign busy = (state_q != ST_IDLE);
  assign bus_addr = addr_q;

  // operand wider than port means more than one beat
  wire req_wider = op_bytes(req_size) > port_bytes(port_width);
  // dram ignores the enable bit and bursts whenever the operand is wider than the port
  wire req_burst = req_wider && (burst_en || dram_hit);
  wire [4:0] req_beats = req_wider ? (op_bytes(req_size) >> port_shift(port_width)) : 5'h01;
  // burst reports the operand; inhibited beats report the port
  wire [1:0] req_wcode = (req_wider && !req_burst) ? port_width : req_size;

  // ------------------------------------------------------------
  // beat address stepping, wrapping inside the operand block
  // ------------------------------------------------------------
  // mask of the low address bits that wrap inside the operand block
  wire [4:0] op_mask5 = op_bytes(size_q) - 5'h01;
  wire [3:0] blk_mask = op_mask5[3:0];
  wire [4:0] step = port_bytes(port_q);
  wire [3:0] low_sum = addr_q[3:0] + step[3:0];
  // line steps the four low bits, longword two, word one
  wire [3:0] low_next = (addr_q[3:0] & ~blk_mask) | (low_sum & blk_mask);
  wire [`EBM_ADDR_W-1:0] addr_next = {addr_q[`EBM_ADDR_W-1:4], low_next};

  // ------------------------------------------------------------
  // write lane placement
  // ------------------------------------------------------------
  wire [`EBM_DATA_W-1:0] wr_lanes;

  ebm_wr_lanes u_wr_lanes (
    .size(size_q),
    .offset(addr_q[1:0]),
    .operand(wdata_q),
    .lanes(wr_lanes)
  );

  // ------------------------------------------------------------
  // ack sampling and bus monitor
  // ------------------------------------------------------------
  // the slave runs on this clock, so the ack is sampled directly
  wire ack = (state_q == ST_DATA) && !cycle_ack_n;
  wire last_beat = (beats_q == 5'h01);
  wire [`EBM_BMT_W-1:0] bmt_next = bmt_cnt_q + 8'h01;
  // limit of zero behaves as a limit of one: no wait state allowed
  wire bmt_hit = (state_q == ST_DATA) && cycle_ack_n && bmt_enable && (bmt_next >= bmt_limit);

  // counts clocks of one beat without ack; restarts per beat
  always @(posedge clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      bmt_cnt_q <= 8'h00;
    end else if (state_q != ST_DATA || ack) begin
      bmt_cnt_q <= 8'h00;
    end else begin
      bmt_cnt_q <= bmt_next;
    end
  end

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      state_q <= ST_IDLE;
      addr_q <= `EBM_ADDR_RST;
      size_q <= `EBM_SZ_LONG;
      port_q <= `EBM_PORT_32;
      write_q <= 1'b0;
      code_q <= 1'b0;
      super_q <= 1'b0;
      burst_q <= 1'b0;
      wdata_q <= `EBM_DATA_RST;
      beats_q <= 5'h00;
      access_kind_code <= `EBM_KIND_RST;
      access_mode_flag <= 1'b0;
      xfer_dir <= `EBM_DIR_READ;
      xfer_width_code <= `EBM_SZ_LONG;
      cycle_start_n <= 1'b1;
      data_out <= `EBM_DATA_RST;
      data_oe_n <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_START;
            addr_q <= req_addr;
            size_q <= req_size;
            port_q <= port_width;
            write_q <= req_write;
            code_q <= req_code;
            super_q <= req_super;
            burst_q <= req_burst;
            wdata_q <= req_wdata;
            beats_q <= req_beats;
            access_kind_code <= req_kind;
            access_mode_flag <= req_code ? `EBM_MODE_CODE : `EBM_MODE_DATA;
            xfer_dir <= req_write ? `EBM_DIR_WRITE : `EBM_DIR_READ;
            xfer_width_code <= req_wcode;
            cycle_start_n <= 1'b0;
            rsp_err <= 1'b0;
          end
        end
        ST_START: begin
          // strobe lasts exactly the first clock
          state_q <= ST_DATA;
          cycle_start_n <= 1'b1;
          access_mode_flag <= super_q ? `EBM_MODE_SUPER : `EBM_MODE_USER;
          if (write_q) begin
            data_out <= wr_lanes;
            data_oe_n <= 1'b0;
          end
        end
        ST_DATA: begin
          if (ack && last_beat) begin
            // last beat: end of transfer, free the data bus
            state_q <= ST_IDLE;
            beats_q <= 5'h00;
            data_oe_n <= 1'b1;
            rsp_valid <= 1'b1;
          end else if (ack) begin
            beats_q <= beats_q - 5'h01;
            addr_q <= addr_next;
            if (!burst_q) begin
              // inhibited beats open a fresh cycle each time
              state_q <= ST_START;
              cycle_start_n <= 1'b0;
              access_mode_flag <= code_q ? `EBM_MODE_CODE : `EBM_MODE_DATA;
            end
          end else if (bmt_hit) begin
            // timeout ends the cycle with an internal bus error
            state_q <= ST_IDLE;
            beats_q <= 5'h00;
            data_oe_n <= 1'b1;
            rsp_valid <= 1'b1;
            rsp_err <= 1'b1;
          end
          // no ack and no timeout: wait state, outputs hold
        end
        default: begin
          state_q <= ST_IDLE;
          cycle_start_n <= 1'b1;
          data_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // read data capture into the operand image
  // ------------------------------------------------------------
  // lanes the port uses: 32-bit all, 16-bit upper two, 8-bit top
  wire [4:0] pb_m1 = port_bytes(port_q) - 5'h01;
  wire [1:0] lane = addr_q[1:0] & pb_m1[1:0];
  // move the addressed lane to the top so the unit is left aligned
  wire [`EBM_DATA_W-1:0] rd_shift = data_in << {lane, 3'b000};
  wire [3:0] rd_off = addr_q[3:0] & blk_mask;
  // bytes delivered per beat is the smaller of operand and port
  wire [4:0] rd_unit = (op_bytes(size_q) < port_bytes(port_q)) ? op_bytes(size_q) : port_bytes(port_q);
  wire rd_take = ack && !write_q;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_rd_byte
      localparam integer IDX_I = gi;
      localparam [3:0] IDX = IDX_I[3:0];
      reg [7:0] byte_q;
      wire [3:0] rel = IDX - rd_off;
      wire hit = (IDX >= rd_off) && ({1'b0, rel} < rd_unit);
      wire [7:0] pick = rd_shift[{~rel[1:0], 3'b000} +: 8];

      // byte 0 of the operand sits in the top bits of the image
      always @(posedge clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
          byte_q <= 8'h00;
        end else if (accept) begin
          byte_q <= 8'h00;
        end else if (rd_take && hit) begin
          byte_q <= pick;
        end
      end

      assign rsp_rdata[(15 - gi) * 8 +: 8] = byte_q;
    end
  endgenerate

endmodule

// *** verilog/ebm_defines.vh ***
// shared codes and widths for the external bus master cycles block
`ifndef EBM_DEFINES_VH
`define EBM_DEFINES_VH

// ------------------------------------------------------------
// bus widths
// ------------------------------------------------------------
`define EBM_ADDR_W 28
`define EBM_DATA_W 32
`define EBM_LINE_W 128
`define EBM_BMT_W 8

// ------------------------------------------------------------
// xfer_width_code values, operand size on the request side
// ------------------------------------------------------------
`define EBM_SZ_LONG 2'h0
`define EBM_SZ_BYTE 2'h1
`define EBM_SZ_WORD 2'h2
`define EBM_SZ_LINE 2'h3

// ------------------------------------------------------------
// port width codes, chosen equal to the matching size codes
// ------------------------------------------------------------
`define EBM_PORT_32 2'h0
`define EBM_PORT_8 2'h1
`define EBM_PORT_16 2'h2

// ------------------------------------------------------------
// direction and access mode levels
// ------------------------------------------------------------
`define EBM_DIR_READ 1'b1
`define EBM_DIR_WRITE 1'b0
`define EBM_MODE_CODE 1'b1
`define EBM_MODE_DATA 1'b0
`define EBM_MODE_SUPER 1'b1
`define EBM_MODE_USER 1'b0

// ------------------------------------------------------------
// reset values of the bus outputs
// ------------------------------------------------------------
`define EBM_ADDR_RST 28'h0000000
`define EBM_DATA_RST 32'h00000000
`define EBM_KIND_RST 2'h0

`endif

// *** verilog/ebm_wr_lanes.v ***
// write data multiplexer from operand bytes onto the four byte lanes
`timescale 1ns/100ps
`include "ebm_defines.vh"

module ebm_wr_lanes (
  size,
  offset,
  operand,
  lanes
);
  input wire [1:0] size;
  input wire [1:0] offset;
  input wire [31:0] operand;
  output reg [31:0] lanes;

  // operand bytes, op0 most significant, op3 least
  wire [7:0] op0 = operand[31:24];
  wire [7:0] op1 = operand[23:16];
  wire [7:0] op2 = operand[15:8];
  wire [7:0] op3 = operand[7:0];

  // lane placement; don't-care lanes are driven as zero
  always @* begin
    lanes = `EBM_DATA_RST;
    case (size)
      `EBM_SZ_BYTE: begin
        case (offset)
          2'h0: lanes = {op3, 8'h00, 8'h00, 8'h00};
          2'h1: lanes = {op3, op3, 8'h00, 8'h00};
          2'h2: lanes = {op3, 8'h00, op3, 8'h00};
          default: lanes = {op3, op3, 8'h00, op3};
        endcase
      end
      `EBM_SZ_WORD: begin
        case (offset)
          2'h0: lanes = {op2, op3, 8'h00, 8'h00};
          2'h2: lanes = {op2, op3, op2, op3};
          default: lanes = {op3, 8'h00, 8'h00, 8'h00};
        endcase
      end
      default: begin
        case (offset)
          2'h0: lanes = {op0, op1, op2, op3};
          2'h1: lanes = {op1, 8'h00, 8'h00, 8'h00};
          2'h2: lanes = {op2, op3, 8'h00, 8'h00};
          default: lanes = {op3, 8'h00, 8'h00, 8'h00};
        endcase
      end
    endcase
  end

endmodule
